// *** crw_params.svh ***
// constants for the coupled ram wrapper: widths, depths, init select bit
// assumes inclusion by the package and by the design modules
`ifndef CRW_PARAMS_SVH
`define CRW_PARAMS_SVH
`define CRW_ADDR_W 12
`define CRW_DATA_W 64
`define CRW_ECC_W 8
`define CRW_BANK_W 36
`define CRW_DEPTH 4096
`define CRW_INIT_SEL_BIT 0
`define CRW_ADDR_RST 12'h000
`endif

// *** crw_pkg.sv ***
// types shared by the coupled ram wrapper modules
// assumes crw_params.svh is on the include path
`default_nettype none
`include "crw_params.svh"
package crw_pkg;
   typedef logic [`CRW_ADDR_W-1:0] crw_addr_t;
   typedef logic [`CRW_BANK_W-1:0] crw_bank_word_t;
   typedef enum logic [2:0] {
      CRW_IDLE = 3'b001,
      CRW_INIT = 3'b010,
      CRW_RUN = 3'b100
   } crw_state_t;
endpackage
`default_nettype wire

// *** crw_bank.sv ***
// one 36-bit ram bank: four data bytes plus four ecc bits
// assumes a registered read one cycle after the select
`default_nettype none
`include "crw_params.svh"
module crw_bank
   import crw_pkg::*;
(
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic sel_i,
   input wire logic we_i,
   input wire crw_addr_t addr_i,
   input wire crw_bank_word_t wdata_i,
   output logic [`CRW_BANK_W-1:0] rdata_o
);
   crw_bank_word_t mem [0:`CRW_DEPTH-1];
   crw_bank_word_t rdata_r;
   crw_bank_word_t rdata_nxt;
   always_comb begin
      rdata_nxt = rdata_r;
      if (sel_i && !we_i) begin
         rdata_nxt = mem[addr_i];
      end
   end
   // no reset on the array: contents are defined by auto-initialization
   always_ff @(posedge clk_i) begin
      if (ce_i && sel_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (ce_i) begin
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// *** crw_wrapper.sv ***
// coupled ram wrapper on the second coupled memory port of the cpu
// assumes one clock shared with the cpu and 64-bit aligned accesses only
// Functional notes
// - slave only, serves cpu-initiated reads and writes
// - reads return stored data and ecc unchanged
// - writes store the cpu ecc output
// - event bus raises single or multibit interrupt
// - capture addresses of single and multibit errors
// - separate status flags for both error kinds
// - check parity on incoming address bus
// - duplicated decode for bank and ecc selects
// - two byte-interleaved 36-bit banks, separate selects, shared write enable and address
// - auto-init writes banks with consistent ecc
// - no bit-granular access is offered
// - init starts on global enable and select bit 0
`default_nettype none
`include "crw_params.svh"
module crw_wrapper
   import crw_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic port_en_i,
   input wire logic port_we_i,
   input wire crw_addr_t port_addr_i,
   input wire logic port_addr_par_i,
   input wire logic [`CRW_DATA_W-1:0] port_wdata_i,
   input wire logic [`CRW_ECC_W-1:0] port_wecc_i,
   input wire logic evt_single_i,
   input wire logic evt_multi_i,
   input wire crw_addr_t evt_addr_i,
   input wire logic memory_init_global_enable_i,
   input wire logic [15:0] memory_init_select_i,
   input wire logic clr_single_i,
   input wire logic clr_multi_i,
   input wire logic clr_addr_par_i,
   output logic [`CRW_DATA_W-1:0] port_rdata_o,
   output logic [`CRW_ECC_W-1:0] port_recc_o,
   output logic port_rvalid_o,
   output logic single_irq_o,
   output logic multi_irq_o,
   output logic single_flag_o,
   output logic multi_flag_o,
   output logic [`CRW_ADDR_W-1:0] single_addr_o,
   output logic [`CRW_ADDR_W-1:0] multi_addr_o,
   output logic addr_par_err_o,
   output logic decode_err_o,
   output logic init_busy_o,
   output logic init_done_o
);
   // even parity over address and its parity bit
   function automatic logic par_bad(input crw_addr_t a, input logic p);
      par_bad = ^{a, p};
   endfunction

   // bank select decode, built twice from separate calls so a fault shows
   function automatic logic [1:0] sel_dec(input logic en, input logic bad);
      sel_dec = {en & ~bad, en & ~bad};
   endfunction

   // second decoder in inverted form, so one stuck gate cannot hit both copies
   function automatic logic [1:0] sel_dec_alt(input logic en, input logic bad);
      sel_dec_alt = ~{~en | bad, ~en | bad};
   endfunction

   // split a 64+8 word into the two byte-interleaved banks
   function automatic crw_bank_word_t bank_pack(input logic [63:0] d,
                                                input logic [7:0] e,
                                                input logic odd);
      crw_bank_word_t w;
      w = '0;
      for (int i = 0; i < 4; i++) begin
         w[i*8 +: 8] = d[(2*i + (odd ? 1 : 0))*8 +: 8];
         w[32 + i] = e[2*i + (odd ? 1 : 0)];
      end
      bank_pack = w;
   endfunction

   crw_state_t state_r, state_nxt;
   crw_addr_t init_addr_r, init_addr_nxt;
   logic init_done_r, init_done_nxt;
   logic busy_r, busy_nxt;
   logic rvalid_r, rvalid_nxt;
   logic single_flag_r, single_flag_nxt;
   logic multi_flag_r, multi_flag_nxt;
   logic single_irq_r, single_irq_nxt;
   logic multi_irq_r, multi_irq_nxt;
   crw_addr_t single_addr_r, single_addr_nxt;
   crw_addr_t multi_addr_r, multi_addr_nxt;
   logic apar_r, apar_nxt;
   logic dec_err_r, dec_err_nxt;
   logic [`CRW_DATA_W-1:0] rdata_r, rdata_nxt;
   logic [`CRW_ECC_W-1:0] recc_r, recc_nxt;
   logic rd_pend_r, rd_pend_nxt;

   logic bad;
   logic [1:0] dec_a, dec_b;
   logic init_go;
   logic sel_even, sel_odd, we_any;
   crw_addr_t bank_addr;
   crw_bank_word_t wr_even, wr_odd, rd_even, rd_odd;
   logic [`CRW_DATA_W-1:0] rd_data;
   logic [`CRW_ECC_W-1:0] rd_ecc;

   assign bad = par_bad(port_addr_i, port_addr_par_i);
   assign dec_a = sel_dec(port_en_i && state_r == CRW_RUN, bad);
   assign dec_b = sel_dec_alt(port_en_i && state_r == CRW_RUN, bad);
   assign init_go = memory_init_global_enable_i
                    && memory_init_select_i[`CRW_INIT_SEL_BIT];

   // controls: init owns both banks while busy, otherwise the cpu port
   always_comb begin
      if (state_r == CRW_INIT) begin
         sel_even = 1'b1;
         sel_odd = 1'b1;
         we_any = 1'b1;
         bank_addr = init_addr_r;
         wr_even = '0; // all-zero data has all-zero code: consistent
         wr_odd = '0;
      end else begin
         sel_even = dec_a[0];
         sel_odd = dec_b[1];
         we_any = port_we_i;
         bank_addr = port_addr_i;
         wr_even = bank_pack(port_wdata_i, port_wecc_i, 1'b0);
         wr_odd = bank_pack(port_wdata_i, port_wecc_i, 1'b1);
      end
   end

   crw_bank u_even (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .sel_i(sel_even),
      .we_i(we_any),
      .addr_i(bank_addr),
      .wdata_i(wr_even),
      .rdata_o(rd_even)
   );

   crw_bank u_odd (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .sel_i(sel_odd),
      .we_i(we_any),
      .addr_i(bank_addr),
      .wdata_i(wr_odd),
      .rdata_o(rd_odd)
   );

   // reassemble bytes; no masking anywhere, only whole-word transfers
   always_comb begin
      rd_data = '0;
      rd_ecc = '0;
      for (int i = 0; i < 4; i++) begin
         rd_data[(2*i)*8 +: 8] = rd_even[i*8 +: 8];
         rd_data[(2*i+1)*8 +: 8] = rd_odd[i*8 +: 8];
         rd_ecc[2*i] = rd_even[32 + i];
         rd_ecc[2*i+1] = rd_odd[32 + i];
      end
   end

   // sequencer and port answer
   always_comb begin
      state_nxt = state_r;
      init_addr_nxt = init_addr_r;
      init_done_nxt = init_done_r;
      busy_nxt = busy_r;
      rd_pend_nxt = 1'b0;
      rvalid_nxt = 1'b0;
      rdata_nxt = rdata_r;
      recc_nxt = recc_r;
      dec_err_nxt = dec_err_r | (dec_a != dec_b);
      unique case (state_r)
         CRW_IDLE: begin
            if (init_go) begin
               state_nxt = CRW_INIT;
               init_addr_nxt = `CRW_ADDR_RST;
               init_done_nxt = 1'b0;
               busy_nxt = 1'b1;
            end else begin
               state_nxt = CRW_RUN;
            end
         end
         CRW_INIT: begin
            init_addr_nxt = init_addr_r + 1'b1;
            if (init_addr_r == crw_addr_t'(`CRW_DEPTH - 1)) begin
               state_nxt = CRW_RUN;
               init_done_nxt = 1'b1;
               busy_nxt = 1'b0;
            end
         end
         CRW_RUN: begin
            rd_pend_nxt = dec_a[0] && dec_b[1] && !port_we_i;
            // init waits for a quiet port so no request is lost half-way
            if (init_go && !port_en_i) begin
               state_nxt = CRW_INIT;
               init_addr_nxt = `CRW_ADDR_RST;
               init_done_nxt = 1'b0;
               busy_nxt = 1'b1;
            end
         end
         // an upset state code falls back to idle, which restarts cleanly
         default: begin
            state_nxt = CRW_IDLE;
         end
      endcase
      if (rd_pend_r) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_data;
         recc_nxt = rd_ecc;
      end
   end

   // error capture; a new event wins over a clear in the same cycle
   always_comb begin
      single_flag_nxt = single_flag_r;
      multi_flag_nxt = multi_flag_r;
      single_addr_nxt = single_addr_r;
      multi_addr_nxt = multi_addr_r;
      apar_nxt = apar_r;
      if (clr_single_i) begin
         single_flag_nxt = 1'b0;
      end
      if (clr_multi_i) begin
         multi_flag_nxt = 1'b0;
      end
      if (clr_addr_par_i) begin
         apar_nxt = 1'b0;
      end
      if (evt_single_i) begin
         single_flag_nxt = 1'b1;
         single_addr_nxt = evt_addr_i;
      end
      if (evt_multi_i) begin
         multi_flag_nxt = 1'b1;
         multi_addr_nxt = evt_addr_i;
      end
      if (port_en_i && bad) begin
         apar_nxt = 1'b1;
      end
      single_irq_nxt = evt_single_i;
      multi_irq_nxt = evt_multi_i;
   end

   // ce low freezes every register here; the banks gate their writes the same way
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= CRW_IDLE;
         init_addr_r <= `CRW_ADDR_RST;
         init_done_r <= 1'b0;
         busy_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         recc_r <= '0;
         dec_err_r <= 1'b0;
         single_flag_r <= 1'b0;
         multi_flag_r <= 1'b0;
         single_addr_r <= `CRW_ADDR_RST;
         multi_addr_r <= `CRW_ADDR_RST;
         apar_r <= 1'b0;
         single_irq_r <= 1'b0;
         multi_irq_r <= 1'b0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         init_addr_r <= init_addr_nxt;
         init_done_r <= init_done_nxt;
         busy_r <= busy_nxt;
         rd_pend_r <= rd_pend_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         recc_r <= recc_nxt;
         dec_err_r <= dec_err_nxt;
         single_flag_r <= single_flag_nxt;
         multi_flag_r <= multi_flag_nxt;
         single_addr_r <= single_addr_nxt;
         multi_addr_r <= multi_addr_nxt;
         apar_r <= apar_nxt;
         single_irq_r <= single_irq_nxt;
         multi_irq_r <= multi_irq_nxt;
      end
   end

   assign port_rdata_o = rdata_r;
   assign port_recc_o = recc_r;
   assign port_rvalid_o = rvalid_r;
   assign single_irq_o = single_irq_r;
   assign multi_irq_o = multi_irq_r;
   assign single_flag_o = single_flag_r;
   assign multi_flag_o = multi_flag_r;
   assign single_addr_o = single_addr_r;
   assign multi_addr_o = multi_addr_r;
   assign addr_par_err_o = apar_r;
   assign decode_err_o = dec_err_r;
   assign init_busy_o = busy_r;
   assign init_done_o = init_done_r;
endmodule
`default_nettype wire

// *** crw_wrapper_assertions.sv ***
// checker for port, event and init timing of the coupled ram wrapper
// assumes binding into crw_wrapper; ce_i stays high during init
`default_nettype none
`include "crw_params.svh"
module crw_wrapper_chk
   import crw_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic port_en_i,
   input wire logic port_we_i,
   input wire crw_addr_t port_addr_i,
   input wire logic port_addr_par_i,
   input wire logic evt_single_i,
   input wire logic evt_multi_i,
   input wire crw_addr_t evt_addr_i,
   input wire logic clr_single_i,
   input wire logic [`CRW_DATA_W-1:0] port_rdata_o,
   input wire logic port_rvalid_o,
   input wire logic single_irq_o,
   input wire logic multi_irq_o,
   input wire logic single_flag_o,
   input wire logic [`CRW_ADDR_W-1:0] single_addr_o,
   input wire logic [`CRW_ADDR_W-1:0] multi_addr_o,
   input wire logic addr_par_err_o,
   input wire logic decode_err_o,
   input wire logic init_busy_o,
   input wire logic init_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_go, bad_par;
   logic [12:0] cnt_r, cnt_nxt;
   assign bad_par = ^{port_addr_i, port_addr_par_i};
   assign rd_go = ce_i && port_en_i && !port_we_i && !bad_par && !init_busy_o;
   // counts busy cycles so the init length is checked without a long repetition
   always_comb begin
      cnt_nxt = init_busy_o ? cnt_r + 13'h0001 : 13'h0000;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 13'h0000;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   a_read_answer: assert property (rd_go |-> ##2 port_rvalid_o)
      else $error("read not answered in two cycles");
   a_rvalid_cause: assert property (port_rvalid_o |-> $past(rd_go, 2))
      else $error("read data without a request");
   a_rdata_hold: assert property (!port_rvalid_o |-> $stable(port_rdata_o))
      else $error("read data changed between reads");
   a_single_evt: assert property (ce_i && evt_single_i |=> single_irq_o
      && single_flag_o && single_addr_o == $past(evt_addr_i))
      else $error("single event missed");
   a_multi_evt: assert property (ce_i && evt_multi_i |=> multi_irq_o
      && multi_addr_o == $past(evt_addr_i))
      else $error("multi event missed");
   a_flag_hold: assert property (single_flag_o && !clr_single_i |=> single_flag_o)
      else $error("single flag dropped");
   a_par_check: assert property (ce_i && port_en_i && bad_par && !init_busy_o
      |=> addr_par_err_o) else $error("address parity not flagged");
   a_init_len: assert property ($fell(init_busy_o) |-> cnt_r == 13'h1000
      && init_done_o) else $error("init length wrong");
   a_decode_ok: assert property (!decode_err_o) else $error("decoders disagree");
endmodule
bind crw_wrapper crw_wrapper_chk crw_wrapper_chk_i (.clk_i, .rst_i, .ce_i, .port_en_i,
   .port_we_i, .port_addr_i, .port_addr_par_i, .evt_single_i, .evt_multi_i, .evt_addr_i,
   .clr_single_i, .port_rdata_o, .port_rvalid_o, .single_irq_o, .multi_irq_o,
   .single_flag_o, .single_addr_o, .multi_addr_o, .addr_par_err_o, .decode_err_o,
   .init_busy_o, .init_done_o);
`default_nettype wire

// *** crw_cpu_model.sv ***
// cpu-side model: checks each read against its code, reports errors as events
// assumes one read in flight at a time
`default_nettype none
`include "crw_params.svh"
module crw_cpu_model
   import crw_pkg::*;
(
   input wire logic clk_i,
   input wire logic port_en_i,
   input wire logic port_we_i,
   input wire crw_addr_t port_addr_i,
   input wire logic [`CRW_DATA_W-1:0] port_rdata_i,
   input wire logic [`CRW_ECC_W-1:0] port_recc_i,
   input wire logic port_rvalid_i,
   output logic evt_single_o,
   output logic evt_multi_o,
   output crw_addr_t evt_addr_o
);
   crw_addr_t rd_addr;
   logic [7:0] syn;
   initial begin
      evt_single_o = 1'b0;
      evt_multi_o = 1'b0;
      evt_addr_o = 12'h000;
   end
   // event reporting is always on in this model
   always @(posedge clk_i) begin
      if (port_en_i && !port_we_i) rd_addr <= port_addr_i;
      syn = port_recc_i;
      for (int i = 0; i < 8; i++) syn ^= port_rdata_i[i*8 +: 8];
      evt_single_o <= port_rvalid_i && $countones(syn) == 1;
      evt_multi_o <= port_rvalid_i && $countones(syn) > 1;
      // address is only meaningful with a pulse, so it wanders otherwise
      evt_addr_o <= port_rvalid_i ? rd_addr : ~evt_addr_o;
   end
endmodule
`default_nettype wire

// *** crw_wrapper_tb.sv ***
// self-checking bench for the coupled ram wrapper with a cpu-side model
// assumes the checker is bound in and crw_params.svh is reachable
`default_nettype none
`include "crw_params.svh"
module crw_wrapper_tb
   import crw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i, rst_i, ce, en, we, apar, gen, csg, cml, cpa, rv, sirq, mirq;
   logic sfl, mfl, perr, derr, busy, done, esg, eml;
   crw_addr_t addr, eaddr, ta [8];
   logic [15:0] msel;
   logic [63:0] wd, rd, d64;
   logic [7:0] wecc, recc;
   logic [11:0] sad, mad;
   logic [71:0] mem [int];
   int err_count, tests_run, seed, n;
   crw_wrapper crw_wrapper_i (.clk_i, .rst_i, .ce_i(ce), .port_en_i(en), .port_we_i(we),
      .port_addr_i(addr), .port_addr_par_i(apar), .port_wdata_i(wd), .port_wecc_i(wecc),
      .evt_single_i(esg), .evt_multi_i(eml), .evt_addr_i(eaddr),
      .memory_init_global_enable_i(gen), .memory_init_select_i(msel),
      .clr_single_i(csg), .clr_multi_i(cml), .clr_addr_par_i(cpa), .port_rdata_o(rd),
      .port_recc_o(recc), .port_rvalid_o(rv), .single_irq_o(sirq), .multi_irq_o(mirq),
      .single_flag_o(sfl), .multi_flag_o(mfl), .single_addr_o(sad), .multi_addr_o(mad),
      .addr_par_err_o(perr), .decode_err_o(derr), .init_busy_o(busy), .init_done_o(done));
   crw_cpu_model crw_cpu_model_i (.clk_i, .port_en_i(en), .port_we_i(we),
      .port_addr_i(addr), .port_rdata_i(rd), .port_recc_i(recc), .port_rvalid_i(rv),
      .evt_single_o(esg), .evt_multi_o(eml), .evt_addr_o(eaddr));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [7:0] code(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 8; i++) c ^= d[i*8 +: 8];
      return c;
   endfunction
   task automatic chk(input logic [75:0] got, input logic [75:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      if (err_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task step;
      @(posedge clk_i);
      #2;
   endtask
   // leaves the request up, so back-to-back calls never pulse en twice in one step
   task automatic acc(input logic w, input crw_addr_t a, input logic [63:0] d,
      input logic [7:0] e, input logic bad);
      en = 1'b1;
      we = w;
      addr = a;
      apar = ^a ^ bad;
      wd = d;
      wecc = e;
      step;
      if (w && !bad) mem[a] = {e, d};
   endtask
   task idle;
      en = 1'b0;
      wd = ~wd;
   endtask
   task automatic rd_chk(input crw_addr_t a);
      logic [71:0] ex;
      ex = mem.exists(a) ? mem[a] : 72'h0;
      acc(1'b0, a, wd, wecc, 1'b0);
      idle;
      step;
      chk(rv, 1'b1);
      chk({recc, rd}, ex);
   endtask
   initial begin
      #2500000;
      err_count++;
      report_and_stop;
   end
   initial begin
      seed = 32'h17F0;
      {err_count, tests_run} = 0;
      {rst_i, ce} = 2'b11;
      {en, we, apar, gen, csg, cml, cpa, addr, wd, wecc, msel} = 0;
      repeat (20) @(posedge clk_i);
      #2 rst_i = 1'b0;
      chk({sfl, mfl, perr, busy, done, rv}, 0);
      step;
      step;
      gen = 1'b1;
      msel = 16'hFFFE;
      repeat (4) step;
      chk(busy, 1'b0);
      msel = 16'h0001;
      for (n = 0; n < 4 && busy !== 1'b1; n++) step;
      chk(busy, 1'b1);
      if (busy !== 1'b1) report_and_stop;
      gen = 1'b0;
      for (n = 0; n < 5000 && busy !== 1'b0; n++) step;
      chk({busy, done}, 2'b01);
      if (busy !== 1'b0) report_and_stop;
      rd_chk(12'hFFF);
      for (int i = 0; i < 8; i++) begin
         ta[i] = crw_addr_t'($random(seed));
         d64 = {$random(seed), $random(seed)};
         acc(1'b1, ta[i], d64, code(d64), 1'b0);
      end
      for (int i = 0; i < 8; i++) rd_chk(ta[i]);
      chk({sfl, mfl}, 2'b00);
      acc(1'b1, 12'h0A5, d64, code(d64) ^ 8'h01, 1'b0);
      acc(1'b1, 12'hF5A, ~d64, code(~d64) ^ 8'h03, 1'b0);
      rd_chk(12'h0A5);
      step;
      step;
      chk({sirq, sfl, mfl, sad}, {3'b110, 12'h0A5});
      rd_chk(12'hF5A);
      step;
      step;
      chk({mirq, sfl, mfl, mad, sad}, {3'b111, 12'hF5A, 12'h0A5});
      csg = 1'b1;
      step;
      csg = 1'b0;
      step;
      chk({sfl, mfl}, 2'b01);
      cml = 1'b1;
      step;
      cml = 1'b0;
      step;
      chk(mfl, 1'b0);
      acc(1'b1, ta[0], ~wd, 8'hFF, 1'b1);
      idle;
      step;
      chk(perr, 1'b1);
      rd_chk(ta[0]);
      step;
      ce = 1'b0;
      cpa = 1'b1;
      step;
      chk(perr, 1'b1);
      ce = 1'b1;
      step;
      cpa = 1'b0;
      step;
      chk({perr, derr}, 2'b00);
      report_and_stop;
   end
endmodule
`default_nettype wire
